// ===== logic/gpgc_pkg.sv
// package: offsets, field positions, reset values and encodings of the general registers
package gpgc_pkg;

  // ******************************
  // register byte offsets
  // ******************************
  localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INT_SUMMARY    = 8'h04;
  localparam logic [7:0] OFS_PORT_DIRECTION = 8'h08;
  localparam logic [7:0] OFS_PULL_SELECT    = 8'h0c;
  localparam logic [7:0] OFS_SIMUL_COMMAND  = 8'h10;
  localparam logic [7:0] OFS_PORT_VALUE_LO  = 8'hd0;
  localparam logic [7:0] OFS_PORT_VALUE_HI  = 8'hdf;

  // ******************************
  // geometry
  // ******************************
  localparam int NUM_PORTS  = 16;
  localparam int PORT_WIDTH = 8;
  localparam int HALF_PORTS = 8;
  localparam int GROUP_SIZE = 4;
  localparam int NUM_GROUPS = 4;
  localparam logic [3:0] LAST_PORT = 4'hf;

  // ******************************
  // field positions
  // ******************************
  localparam int SUM_TIMER1_BIT   = 10;
  localparam int SUM_TIMER0_BIT   = 9;
  localparam int SUM_WATCHDOG_BIT = 8;
  localparam int SUM_RISE_LSB     = 4;
  localparam int SUM_FALL_LSB     = 0;
  localparam int CMD_DRIVE_UP     = 9;
  localparam int CMD_DRIVE_LO     = 8;
  localparam int CMD_CAPT_UP      = 1;
  localparam int CMD_CAPT_LO      = 0;
  localparam int GCR_OUT_UP       = 5;
  localparam int GCR_OUT_LO       = 4;
  localparam int GCR_IN_UP        = 1;
  localparam int GCR_IN_LO        = 0;

  // ******************************
  // reset values and encodings
  // ******************************
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [31:0] GCR_RW_MASK = 32'h0000_0033;

  typedef enum logic [1:0] {
    PULL_DOWN   = 2'b00,
    PULL_UP_5V  = 2'b01,
    PULL_UP_3V3 = 2'b10,
    PULL_NONE   = 2'b11
  } gpgc_pull_t;

endpackage : gpgc_pkg

// ===== logic/gpgc_port_slice.sv
// one 8-bit port: output latch, input capture and pin drive
module gpgc_port_slice
  import gpgc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // control
  input  wire logic        portOut,
  input  wire logic        connected,
  input  wire logic        outMode,
  input  wire logic        inMode,
  input  wire logic        driveStrobe,
  input  wire logic        captureStrobe,
  input  wire logic        dataWrite,
  input  wire logic [7:0]  dataIn,
  input  wire logic [1:0]  pullField,
  // pins
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOe,
  output gpgc_pull_t       pullSel,
  // readback
  output logic      [7:0]  portValue
);

  logic [7:0] pendOut_ff;
  logic [7:0] pinOut_ff;
  logic [7:0] capt_ff;

  // ******************************
  // output path
  // ******************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pendOut_ff <= RST_BYTE;
    end else if (dataWrite) begin
      pendOut_ff <= dataIn;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinOut_ff <= RST_BYTE;
    end else if (!outMode && dataWrite) begin
      pinOut_ff <= dataIn;
    end else if (outMode && driveStrobe && portOut) begin
      pinOut_ff <= pendOut_ff;
    end
  end

  // ******************************
  // input capture
  // ******************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      capt_ff <= RST_BYTE;
    end else if (inMode && captureStrobe && !portOut) begin
      capt_ff <= pinIn;
    end
  end

  assign pinOe   = (portOut && connected) ? 8'hff : 8'h00;
  assign pinOut  = pinOut_ff;
  assign pullSel = connected ? gpgc_pull_t'(pullField) : PULL_NONE;
  assign portValue = portOut ? (outMode ? pendOut_ff : pinOut_ff)
                             : (inMode ? capt_ff : pinIn);

endmodule : gpgc_port_slice

// ===== logic/gpgc_general_regs.sv
// general control registers of the sixteen-port digital i/o function
// Contract
// - summary bits 10,9,8 show timer1, timer0, watchdog interrupt requests
// - summary bits 7..4 show rising-edge pending per four-port group
// - summary bits 3..0 show falling-edge pending per four-port group
// - all eight lines of a port share one direction
// - direction bit n sets port n; 1 output, reset makes all inputs
// - two-bit pull field per port: 00 down, 01 5V, 10 3.3V, 11 none
// - command bit 9 drives pending outputs of ports 15..8 at once
// - command bit 8 drives pending outputs of ports 7..0 at once
// - command bit 1 captures inputs of ports 15..8, frozen until rewritten
// - command bit 0 captures inputs of ports 7..0, frozen until rewritten
// - command register always reads zero
// - unwired port 15 variant: its direction and pull have no pin effect
// - drive and capture act only with matching simultaneous enable set
module gpgc_general_regs
  import gpgc_pkg::*;
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // build variant
  input  wire logic                    port15Wired,
  // register port
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWdata,
  output logic      [31:0]             regRdata,
  // timer and watchdog requests
  input  wire logic                    timer1Irq,
  input  wire logic                    timer0Irq,
  input  wire logic                    watchdogIrq,
  // edge interrupt status
  input  wire logic [NUM_PORTS*8-1:0]  riseEdgeStatus,
  input  wire logic [NUM_PORTS*8-1:0]  fallEdgeStatus,
  // port lines in
  input  wire logic [NUM_PORTS*8-1:0]  pinIn,
  // port drive and pulls
  output logic      [NUM_PORTS*8-1:0]  pinOut,
  output logic      [NUM_PORTS*8-1:0]  pinOe,
  output logic      [NUM_PORTS*2-1:0]  pullSel
);

  logic [31:0]             globalCtrl_ff;
  logic [15:0]             portDirection_ff;
  logic [31:0]             portPullSelect_ff;
  logic [31:0]             intSummary_ff;
  logic [31:0]             regRdata_ff;
  logic [31:0]             nxt_regRdata;
  logic [31:0]             nxt_summary;
  logic [NUM_PORTS*8-1:0]  portValue;
  logic                    cmdWrite;
  logic                    wordHit;
  logic [3:0]              portIdx;
  logic                    hitGlobal;
  logic                    hitDirection;
  logic                    hitPull;
  logic                    hitCommand;
  logic                    driveUpper;
  logic                    driveLower;
  logic                    captUpper;
  logic                    captLower;
  logic [NUM_GROUPS-1:0]   riseGroup;
  logic [NUM_GROUPS-1:0]   fallGroup;
  logic [7:0]              portRead;

  // ******************************
  // address decode
  // ******************************
  assign hitGlobal    = (regAddr == OFS_GLOBAL_CONTROL);
  assign hitDirection = (regAddr == OFS_PORT_DIRECTION);
  assign hitPull      = (regAddr == OFS_PULL_SELECT);
  assign hitCommand   = (regAddr == OFS_SIMUL_COMMAND);
  assign cmdWrite = regWrite && hitCommand;
  assign wordHit  = (regAddr >= OFS_PORT_VALUE_LO) && (regAddr <= OFS_PORT_VALUE_HI);
  assign portIdx  = regAddr[3:0];

  // ******************************
  // command strobes per half
  // ******************************
  // upper drive command
  assign driveUpper = cmdWrite && regWdata[CMD_DRIVE_UP];
  assign driveLower = cmdWrite && regWdata[CMD_DRIVE_LO];
  assign captUpper  = cmdWrite && regWdata[CMD_CAPT_UP];
  assign captLower  = cmdWrite && regWdata[CMD_CAPT_LO];

  // ******************************
  // writable registers
  // ******************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      globalCtrl_ff <= RST_WORD;
    end else if (regWrite && hitGlobal) begin
      globalCtrl_ff <= regWdata & GCR_RW_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      portDirection_ff <= 16'h0000;
    end else if (regWrite && hitDirection) begin
      portDirection_ff <= regWdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      portPullSelect_ff <= RST_WORD;
    end else if (regWrite && hitPull) begin
      portPullSelect_ff <= regWdata;
    end
  end

  // ******************************
  // interrupt summary
  // ******************************
  always_comb begin
    nxt_summary = RST_WORD;
    nxt_summary[SUM_TIMER1_BIT]   = timer1Irq;
    nxt_summary[SUM_TIMER0_BIT]   = timer0Irq;
    nxt_summary[SUM_WATCHDOG_BIT] = watchdogIrq;
    nxt_summary[SUM_RISE_LSB +: NUM_GROUPS] = riseGroup;
    nxt_summary[SUM_FALL_LSB +: NUM_GROUPS] = fallGroup;
  end

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : gGroup
    assign riseGroup[g] = |riseEdgeStatus[g*32 +: 32];
    assign fallGroup[g] = |fallEdgeStatus[g*32 +: 32];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intSummary_ff <= RST_WORD;
    end else begin
      intSummary_ff <= nxt_summary;
    end
  end

  // ******************************
  // port slices
  // ******************************
  for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
    localparam bit UPPER = (p >= HALF_PORTS);
    gpgc_port_slice uSlice (
      .mclk          (mclk),
      .sys_rst       (sys_rst),
      .portOut       (portDirection_ff[p]),
      .connected     ((p == 15) ? port15Wired : 1'b1),
      .outMode       (globalCtrl_ff[UPPER ? GCR_OUT_UP : GCR_OUT_LO]),
      .inMode        (globalCtrl_ff[UPPER ? GCR_IN_UP : GCR_IN_LO]),
      .driveStrobe   (UPPER ? driveUpper : driveLower),
      .captureStrobe (UPPER ? captUpper : captLower),
      .dataWrite     (regWrite && wordHit && portIdx == 4'(p)),
      .dataIn        (regWdata[7:0]),
      .pullField     (portPullSelect_ff[2*p +: 2]),
      .pinIn         (pinIn[p*8 +: 8]),
      .pinOut        (pinOut[p*8 +: 8]),
      .pinOe         (pinOe[p*8 +: 8]),
      .pullSel       (pullSel[2*p +: 2]),
      .portValue     (portValue[p*8 +: 8])
    );
  end

  // ******************************
  // read mux
  // ******************************
  always_comb begin
    nxt_regRdata = RST_WORD;
    case (regAddr)
      OFS_GLOBAL_CONTROL: nxt_regRdata = globalCtrl_ff;
      OFS_INT_SUMMARY:    nxt_regRdata = intSummary_ff;
      OFS_PORT_DIRECTION: nxt_regRdata = {16'h0000, portDirection_ff};
      OFS_PULL_SELECT:    nxt_regRdata = portPullSelect_ff;
      OFS_SIMUL_COMMAND:  nxt_regRdata = RST_WORD;
      default:            nxt_regRdata = {24'h000000, portRead};
    endcase
  end

  // ******************************
  // port data readback
  // ******************************
  always_comb begin
    portRead = RST_BYTE;
    if (wordHit) begin
      portRead = portValue[portIdx*8 +: 8];
    end
  end

  // ******************************
  // readback register
  // ******************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdata_ff <= RST_WORD;
    end else if (regRead) begin
      regRdata_ff <= nxt_regRdata;
    end
  end

  assign regRdata = regRdata_ff;

endmodule : gpgc_general_regs

// ===== bench/gpgc_ext_ports.sv
// partner: outside port lines, echoing driven lines and feeding the rest
module gpgc_ext_ports
  import gpgc_pkg::*;
(
  // pins
  input  wire logic [127:0] pinOut,
  input  wire logic [127:0] pinOe,
  input  wire logic [7:0]   extVal,
  output logic      [127:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int i = 0; i < 128; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extVal[i%8];
    end
  end
endmodule : gpgc_ext_ports

// ===== bench/gpgc_general_regs_asserts.sv
// checker: port properties of the general register block
module gpgc_general_regs_asserts
  import gpgc_pkg::*;
(
  // clock, reset, variant
  input wire logic         mclk,
  input wire logic         sys_rst,
  input wire logic         port15Wired,
  // register port
  input wire logic         regWrite,
  input wire logic         regRead,
  input wire logic [7:0]   regAddr,
  input wire logic [31:0]  regWdata,
  input wire logic [31:0]  regRdata,
  // status and pins
  input wire logic         timer1Irq,
  input wire logic         timer0Irq,
  input wire logic         watchdogIrq,
  input wire logic [127:0] riseEdgeStatus,
  input wire logic [127:0] fallEdgeStatus,
  input wire logic [127:0] pinOut,
  input wire logic [127:0] pinOe,
  input wire logic [31:0]  pullSel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0]  dirCopy_ff;
  logic [31:0]  pullCopy_ff;
  logic [1:0]   outEn_ff;
  logic [10:0]  sumIn;
  logic [127:0] oeExp;
  logic [31:0]  pullExp;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dirCopy_ff  <= '0;
      pullCopy_ff <= '0;
      outEn_ff    <= '0;
    end else if (regWrite) begin
      if (regAddr == OFS_PORT_DIRECTION) dirCopy_ff <= regWdata[15:0];
      if (regAddr == OFS_PULL_SELECT) pullCopy_ff <= regWdata;
      if (regAddr == OFS_GLOBAL_CONTROL) outEn_ff <= regWdata[5:4];
    end
  end
  always_comb begin
    sumIn[10:8] = {timer1Irq, timer0Irq, watchdogIrq};
    for (int g = 0; g < 4; g++) begin
      sumIn[4+g] = |riseEdgeStatus[g*32+:32];
      sumIn[g]   = |fallEdgeStatus[g*32+:32];
    end
    for (int p = 0; p < 16; p++) begin
      oeExp[p*8+:8]   = {8{dirCopy_ff[p] & (p < 15 || port15Wired)}};
      pullExp[p*2+:2] = (p == 15 && !port15Wired) ? 2'b11 : pullCopy_ff[p*2+:2];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_direct;
    regWrite && regAddr == OFS_PORT_VALUE_LO && !outEn_ff[0] && pinOe[0]
      |=> pinOut[7:0] == $past(regWdata[7:0]);
  endproperty
  chk_reset_idle:
  assert property ($fell(sys_rst) |-> pinOe == '0 && pinOut == '0) else $error("pins busy");
  chk_sum_bits:
  assert property (regRead && regAddr == OFS_INT_SUMMARY && $past(sumIn) == sumIn
    && $past(sumIn, 2) == sumIn |=> regRdata == {21'h0, $past(sumIn)}) else $error("summary");
  chk_oe_dir:
  assert property (pinOe == oeExp) else $error("drive enables wrong");
  chk_pull_map:
  assert property (pullSel == pullExp) else $error("pull codes wrong");
  chk_cmd_zero:
  assert property (regRead && regAddr == OFS_SIMUL_COMMAND |=> regRdata == '0) else $error("cmd");
  chk_cmd_gated:
  assert property (regWrite && regAddr == OFS_SIMUL_COMMAND && outEn_ff == 2'b00
    |=> $stable(pinOut)[*2]) else $error("drive without enable");
  chk_direct_out:
  assert property (p_direct) else $error("direct write lost");
  chk_out_cause:
  assert property ($changed(pinOut) |-> $past(regWrite) || $past(regWrite, 2))
    else $error("output moved alone");
  cover property (regRead && regAddr == OFS_INT_SUMMARY && sumIn != '0);
  cover property (regWrite && regAddr == OFS_SIMUL_COMMAND && outEn_ff != 2'b00);
  cover property (regWrite && regAddr == OFS_PORT_VALUE_LO && pinOe[0]);
endmodule : gpgc_general_regs_asserts
bind gpgc_general_regs gpgc_general_regs_asserts u_chk (.mclk, .sys_rst, .port15Wired,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .timer1Irq, .timer0Irq, .watchdogIrq,
  .riseEdgeStatus, .fallEdgeStatus, .pinOut, .pinOe, .pullSel);

// ===== bench/testbench.sv
// testbench: scenarios for the general register block
module testbench
  import gpgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         port15Wired = 1'b1;
  logic         regWrite = 1'b0;
  logic         regRead = 1'b0;
  logic [7:0]   regAddr = '0;
  logic [31:0]  regWdata = '0;
  logic [10:0]  sv = '0;
  logic [7:0]   extVal = '0;
  logic [127:0] riseEdgeStatus = '0;
  logic [127:0] fallEdgeStatus = '0;
  logic [127:0] pinIn, pinOut, pinOe, exp;
  logic [31:0]  regRdata, pullSel;
  int           err_total = 0;
  int           check_count = 0;
  gpgc_general_regs u_dut (.mclk, .sys_rst, .port15Wired, .regWrite, .regRead, .regAddr,
    .regWdata, .regRdata, .timer1Irq(sv[10]), .timer0Irq(sv[9]), .watchdogIrq(sv[8]),
    .riseEdgeStatus, .fallEdgeStatus, .pinIn, .pinOut, .pinOe, .pullSel);
  gpgc_ext_ports u_ext (.pinOut, .pinOe, .extVal, .pinIn);
  task automatic chk(input logic [127:0] got, input logic [127:0] want);
    check_count++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge mclk);
    #1 regWrite = 1'b0;
    @(posedge mclk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr = a;
    regRead = 1'b1;
    @(posedge mclk);
    #1 regRead = 1'b0;
    chk(128'(regRdata), 128'(e));
    @(posedge mclk);
    #1;
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic t_reset();
    chk(pinOe, '0);
    rd(OFS_PORT_DIRECTION, 32'h0);
    rd(OFS_PULL_SELECT, 32'h0);
    rd(OFS_INT_SUMMARY, 32'h0);
    rd(OFS_SIMUL_COMMAND, 32'h0);
    wr(8'he4, 32'hffff_ffff);
    rd(8'he4, 32'h0);
  endtask : t_reset
  task automatic t_summary();
    for (int b = 0; b < 11; b++) begin
      sv = 11'h1 << b;
      riseEdgeStatus = '0;
      fallEdgeStatus = '0;
      for (int g = 0; g < 4; g++) begin
        riseEdgeStatus[g*32+b] = sv[4+g];
        fallEdgeStatus[g*32+31-b] = sv[g];
      end
      repeat (3) @(posedge mclk);
      #1 rd(OFS_INT_SUMMARY, {21'h0, sv});
    end
    sv = '0;
  endtask : t_summary
  task automatic t_dir_pull();
    for (int p = 0; p < 16; p++) exp[p*8+:8] = {8{p == 15 || p == 8 || p == 7 || p == 5 || p == 4 || p == 0}};
    wr(OFS_PORT_DIRECTION, 32'h0000_81b1);
    chk(pinOe, exp);
    rd(OFS_PORT_DIRECTION, 32'h0000_81b1);
    wr(OFS_PULL_SELECT, 32'h1b1b_1b1b);
    rd(OFS_PULL_SELECT, 32'h1b1b_1b1b);
    chk(128'(pullSel), 128'h1b1b_1b1b);
    port15Wired = 1'b0;
    @(posedge mclk);
    #1 chk(128'(pullSel), 128'hdb1b_1b1b);
    chk(128'(pinOe[127:120]), 128'h0);
    port15Wired = 1'b1;
  endtask : t_dir_pull
  task automatic t_direct();
    wr(OFS_GLOBAL_CONTROL, 32'h0);
    wr(OFS_PORT_DIRECTION, 32'h1);
    wr(OFS_PORT_VALUE_LO, 32'h5a);
    chk(128'(pinOut[7:0]), 128'h5a);
    extVal = 8'hc3;
    rd(OFS_PORT_VALUE_LO + 8'h8, 32'hc3);
    wr(OFS_SIMUL_COMMAND, 32'h100);
    chk(128'(pinOut[7:0]), 128'h5a);
  endtask : t_direct
  task automatic t_simul();
    wr(OFS_GLOBAL_CONTROL, 32'h30);
    wr(OFS_PORT_DIRECTION, 32'h101);
    wr(OFS_PORT_VALUE_LO, 32'h3c);
    wr(OFS_PORT_VALUE_LO + 8'h8, 32'h77);
    chk(128'({pinOut[71:64], pinOut[7:0]}), 128'h005a);
    wr(OFS_GLOBAL_CONTROL, 32'h0);
    wr(OFS_SIMUL_COMMAND, 32'h300);
    chk(128'({pinOut[71:64], pinOut[7:0]}), 128'h005a);
    wr(OFS_GLOBAL_CONTROL, 32'h30);
    wr(OFS_SIMUL_COMMAND, 32'h100);
    chk(128'({pinOut[71:64], pinOut[7:0]}), 128'h003c);
    wr(OFS_SIMUL_COMMAND, 32'h200);
    chk(128'({pinOut[71:64], pinOut[7:0]}), 128'h773c);
    rd(OFS_SIMUL_COMMAND, 32'h0);
    wr(OFS_GLOBAL_CONTROL, 32'h3);
    wr(OFS_PORT_DIRECTION, 32'h0);
    extVal = 8'ha1;
    wr(OFS_SIMUL_COMMAND, 32'h3);
    extVal = 8'hb2;
    rd(OFS_PORT_VALUE_LO + 8'h1, 32'ha1);
    rd(OFS_PORT_VALUE_LO + 8'h9, 32'ha1);
    wr(OFS_SIMUL_COMMAND, 32'h1);
    rd(OFS_PORT_VALUE_LO + 8'h1, 32'hb2);
    rd(OFS_PORT_VALUE_LO + 8'h9, 32'ha1);
    wr(OFS_GLOBAL_CONTROL, 32'h1);
    extVal = 8'hc5;
    wr(OFS_SIMUL_COMMAND, 32'h2);
    rd(OFS_PORT_VALUE_LO + 8'h9, 32'hc5);
    wr(OFS_GLOBAL_CONTROL, 32'h3);
    rd(OFS_PORT_VALUE_LO + 8'h9, 32'ha1);
  endtask : t_simul
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #20us;
    err_total++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_summary();
    t_dir_pull();
    t_direct();
    t_simul();
    close_out();
  end
endmodule : testbench
